// File: design/rtci_pkg.sv
// Shared constants for the real-time clock two-wire target and its controller
package rtci_pkg;
   localparam logic [6:0] RTCI_TARGET_ADDR = 7'h51;
   localparam logic RTCI_DIR_READ = 1'b1;
   localparam logic RTCI_DIR_WRITE = 1'b0;
   localparam logic [3:0] RTCI_BYTE_BITS = 4'h8;
   localparam logic [2:0] RTCI_LAST_BIT = 3'h7;
   localparam logic [7:0] RTCI_TEST_PTR_A = 8'h49;
   localparam logic [7:0] RTCI_TEST_PTR_B = 8'h4A;
   localparam logic [7:0] RTCI_PTR_RESET = 8'h00;
   localparam int RTCI_FIFO_DEPTH = 16;
   localparam int RTCI_CLK_PERIOD_NS = 5;
   localparam int RTCI_SCL_PERIOD_NS = 2500;
   localparam int RTCI_QUARTER_CYC = RTCI_SCL_PERIOD_NS / (4 * RTCI_CLK_PERIOD_NS);
   localparam logic [1:0] RTCI_PH_SETUP = 2'h0;
   localparam logic [1:0] RTCI_PH_RISE = 2'h1;
   localparam logic [1:0] RTCI_PH_MID = 2'h2;
   localparam logic [1:0] RTCI_PH_FALL = 2'h3;
   typedef enum logic [2:0] {
      RTCI_D_IDLE = 3'b000,
      RTCI_D_RX = 3'b001,
      RTCI_D_ACK = 3'b011,
      RTCI_D_TX = 3'b010,
      RTCI_D_RACK = 3'b110
   } rtci_dev_st_t;
   typedef enum logic [1:0] {
      RTCI_K_ADDR = 2'b00,
      RTCI_K_PTR = 2'b01,
      RTCI_K_DATA = 2'b11
   } rtci_kind_t;
   typedef enum logic [2:0] {
      RTCI_H_IDLE = 3'b000,
      RTCI_H_START = 3'b001,
      RTCI_H_BITS = 3'b011,
      RTCI_H_STOP = 3'b010,
      RTCI_H_HOLD = 3'b110
   } rtci_host_st_t;
endpackage

// File: design/rtci_bus_if.sv
// Open-drain two-wire bus joining the controller and the clock target
`timescale 1ns/100ps
interface rtci_bus_if;
   logic host_scl_o;
   logic host_scl_oe;
   logic host_sda_o;
   logic host_sda_oe;
   logic dev_sda_o;
   logic dev_sda_oe;
   logic scl;
   logic sda;
   // Pull-ups win unless a party pulls low; nobody ever drives high
   assign scl = !(host_scl_oe && !host_scl_o);
   assign sda = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));
   modport host (
      output host_scl_o,
      output host_scl_oe,
      output host_sda_o,
      output host_sda_oe,
      input sda
   );
   modport device (
      output dev_sda_o,
      output dev_sda_oe,
      input scl,
      input sda
   );
endinterface

// File: design/rtci_target.sv
// Clock-chip two-wire target end with its write-data FIFO
`timescale 1ns/100ps
module rtci_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_idx_q;
   logic [AW-1:0] rd_idx_q;
   logic [AW:0] count_q;
   logic [AW:0] count_d;
   logic push;
   logic pop;

   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = mem_q[rd_idx_q];

   always_comb begin
      count_d = count_q;
      if (push && !pop) begin
         count_d = count_q + 1'b1;
      end else if (pop && !push) begin
         count_d = count_q - 1'b1;
      end
   end

   // Flags come from flops so both sides see clean levels
   always_ff @(posedge clk) begin
      if (rst) begin
         count_q <= '0;
         in_ready <= 1'b0;
         out_valid <= 1'b0;
      end else begin
         count_q <= count_d;
         in_ready <= (count_d != (AW + 1)'(DEPTH));
         out_valid <= (count_d != '0);
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wr_idx_q <= '0;
         rd_idx_q <= '0;
      end else begin
         if (push) begin
            wr_idx_q <= (wr_idx_q == AW'(DEPTH - 1)) ? '0 : wr_idx_q + 1'b1;
         end
         if (pop) begin
            rd_idx_q <= (rd_idx_q == AW'(DEPTH - 1)) ? '0 : rd_idx_q + 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (push) begin
         mem_q[wr_idx_q] <= in_data;
      end
   end
endmodule

module rtci_target
   import rtci_pkg::*;
#(
   parameter logic [6:0] OWN_ADDR = RTCI_TARGET_ADDR,
   parameter int FIFO_DEPTH = RTCI_FIFO_DEPTH
) (
   input wire logic link_clk,
   input wire logic rst,
   rtci_bus_if.device bus,
   output logic [7:0] rd_addr,
   input wire logic [7:0] rd_data,
   output logic wr_valid,
   input wire logic wr_ready,
   output logic [7:0] wr_addr,
   output logic [7:0] wr_data
);
   logic scl_m_q;
   logic scl_s_q;
   logic scl_p_q;
   logic sda_m_q;
   logic sda_s_q;
   logic sda_p_q;
   rtci_dev_st_t st_q;
   rtci_kind_t kind_q;
   logic [3:0] cnt_q;
   logic [7:0] sh_q;
   logic rw_q;
   logic mack_q;
   logic [7:0] ptr_q;
   logic sda_oe_q;
   logic start_seen;
   logic stop_seen;
   logic scl_rise;
   logic scl_fall;
   logic byte_done;
   logic push_valid;
   logic push_ready;

   assign bus.dev_sda_o = 1'b0;
   assign bus.dev_sda_oe = sda_oe_q;
   assign rd_addr = ptr_q;

   // Pins are asynchronous to link_clk; only the second and third stages are looked at
   always_ff @(posedge link_clk) begin
      if (rst) begin
         scl_m_q <= 1'b1;
         scl_s_q <= 1'b1;
         scl_p_q <= 1'b1;
         sda_m_q <= 1'b1;
         sda_s_q <= 1'b1;
         sda_p_q <= 1'b1;
      end else begin
         scl_m_q <= bus.scl;
         scl_s_q <= scl_m_q;
         scl_p_q <= scl_s_q;
         sda_m_q <= bus.sda;
         sda_s_q <= sda_m_q;
         sda_p_q <= sda_s_q;
      end
   end

   assign start_seen = scl_s_q && scl_p_q && sda_p_q && !sda_s_q;
   assign stop_seen = scl_s_q && scl_p_q && !sda_p_q && sda_s_q;
   assign scl_rise = scl_s_q && !scl_p_q;
   assign scl_fall = !scl_s_q && scl_p_q;
   assign byte_done = (st_q == RTCI_D_RX) && scl_fall && (cnt_q == RTCI_BYTE_BITS);
   assign push_valid = byte_done && (kind_q == RTCI_K_DATA);

   // Writes go out through the FIFO; a full FIFO makes the byte go unacknowledged
   rtci_fifo #(
      .WIDTH(16),
      .DEPTH(FIFO_DEPTH)
   ) u_wr_fifo (
      .clk(link_clk),
      .rst(rst),
      .in_valid(push_valid),
      .in_ready(push_ready),
      .in_data({ptr_q, sh_q}),
      .out_valid(wr_valid),
      .out_ready(wr_ready),
      .out_data({wr_addr, wr_data})
   );

   always_ff @(posedge link_clk) begin
      if (rst) begin
         st_q <= RTCI_D_IDLE;
         kind_q <= RTCI_K_ADDR;
         cnt_q <= '0;
         sh_q <= '0;
         rw_q <= RTCI_DIR_WRITE;
         mack_q <= 1'b0;
         ptr_q <= RTCI_PTR_RESET;
         sda_oe_q <= 1'b0;
      end else if (start_seen) begin
         // A start inside a frame is a restart: address reception begins anew
         st_q <= RTCI_D_RX;
         kind_q <= RTCI_K_ADDR;
         cnt_q <= '0;
         sda_oe_q <= 1'b0;
      end else if (stop_seen) begin
         st_q <= RTCI_D_IDLE;
         sda_oe_q <= 1'b0;
      end else begin
         unique case (st_q)
            RTCI_D_IDLE: begin
               sda_oe_q <= 1'b0;
            end
            RTCI_D_RX: begin
               if (scl_rise && cnt_q != RTCI_BYTE_BITS) begin
                  sh_q <= {sh_q[6:0], sda_s_q};
                  cnt_q <= cnt_q + 1'b1;
               end else if (byte_done) begin
                  cnt_q <= '0;
                  unique case (kind_q)
                     RTCI_K_ADDR: begin
                        if (sh_q[7:1] == OWN_ADDR) begin
                           rw_q <= sh_q[0];
                           st_q <= RTCI_D_ACK;
                           sda_oe_q <= 1'b1;
                        end else begin
                           st_q <= RTCI_D_IDLE;
                        end
                     end
                     RTCI_K_PTR: begin
                        ptr_q <= sh_q;
                        st_q <= RTCI_D_ACK;
                        sda_oe_q <= 1'b1;
                     end
                     RTCI_K_DATA: begin
                        if (push_ready) begin
                           ptr_q <= ptr_q + 1'b1;
                           st_q <= RTCI_D_ACK;
                           sda_oe_q <= 1'b1;
                        end else begin
                           st_q <= RTCI_D_IDLE;
                        end
                     end
                     default: begin
                        st_q <= RTCI_D_IDLE;
                     end
                  endcase
               end
            end
            RTCI_D_ACK: begin
               if (scl_fall) begin
                  cnt_q <= '0;
                  if (kind_q == RTCI_K_ADDR && rw_q == RTCI_DIR_READ) begin
                     // Read without pointer setup returns the byte at the current pointer
                     st_q <= RTCI_D_TX;
                     sh_q <= rd_data;
                     sda_oe_q <= !rd_data[7];
                  end else begin
                     st_q <= RTCI_D_RX;
                     kind_q <= (kind_q == RTCI_K_ADDR) ? RTCI_K_PTR : RTCI_K_DATA;
                     sda_oe_q <= 1'b0;
                  end
               end
            end
            RTCI_D_TX: begin
               if (scl_fall) begin
                  if (cnt_q[2:0] == RTCI_LAST_BIT) begin
                     st_q <= RTCI_D_RACK;
                     sda_oe_q <= 1'b0;
                     ptr_q <= ptr_q + 1'b1;
                  end else begin
                     sh_q <= {sh_q[6:0], 1'b0};
                     sda_oe_q <= !sh_q[6];
                     cnt_q <= cnt_q + 1'b1;
                  end
               end
            end
            RTCI_D_RACK: begin
               if (scl_rise) begin
                  mack_q <= !sda_s_q;
               end else if (scl_fall) begin
                  cnt_q <= '0;
                  if (mack_q) begin
                     st_q <= RTCI_D_TX;
                     sh_q <= rd_data;
                     sda_oe_q <= !rd_data[7];
                  end else begin
                     // No ack from the controller: stay off the line until stop
                     st_q <= RTCI_D_IDLE;
                     sda_oe_q <= 1'b0;
                  end
               end
            end
            default: begin
               st_q <= RTCI_D_IDLE;
               sda_oe_q <= 1'b0;
            end
         endcase
      end
   end
endmodule

// File: design/rtci_controller.sv
// Two-wire bus controller end that drives the clock target byte by byte
`timescale 1ns/100ps
module rtci_controller
   import rtci_pkg::*;
#(
   parameter int QUARTER_CYC = RTCI_QUARTER_CYC
) (
   input wire logic ref_clk,
   input wire logic rst,
   rtci_bus_if.host bus,
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire logic cmd_start,
   input wire logic cmd_stop,
   input wire logic cmd_read,
   input wire logic cmd_nack,
   input wire logic [7:0] cmd_data,
   output logic rsp_valid,
   output logic [7:0] rsp_data,
   output logic rsp_ack
);
   localparam int DW = $clog2(QUARTER_CYC + 1);
   logic [DW-1:0] div_q;
   logic tick;
   logic sda_m_q;
   logic sda_s_q;
   rtci_host_st_t st_q;
   logic [1:0] ph_q;
   logic [3:0] bit_q;
   logic [7:0] tx_q;
   logic [7:0] rx_q;
   logic stop_q;
   logic read_q;
   logic nack_q;
   logic addr_wr_q;
   logic ptr_next_q;
   logic scl_oe_q;
   logic sda_oe_q;
   logic take;
   logic bad_ptr;

   assign bus.host_scl_o = 1'b0;
   assign bus.host_sda_o = 1'b0;
   assign bus.host_scl_oe = scl_oe_q;
   assign bus.host_sda_oe = sda_oe_q;
   assign tick = (div_q == DW'(QUARTER_CYC - 1));
   assign take = cmd_valid && cmd_ready;
   assign bad_ptr = ptr_next_q && !cmd_start && !cmd_read
      && (cmd_data == RTCI_TEST_PTR_A || cmd_data == RTCI_TEST_PTR_B);

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         sda_m_q <= 1'b1;
         sda_s_q <= 1'b1;
      end else begin
         sda_m_q <= bus.sda;
         sda_s_q <= sda_m_q;
      end
   end

   // SCL is divided from ref_clk: four quarter steps per bit
   always_ff @(posedge ref_clk) begin
      if (rst || tick) begin
         div_q <= '0;
      end else begin
         div_q <= div_q + 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         st_q <= RTCI_H_IDLE;
         ph_q <= RTCI_PH_SETUP;
         bit_q <= '0;
         tx_q <= '0;
         rx_q <= '0;
         stop_q <= 1'b0;
         read_q <= 1'b0;
         nack_q <= 1'b0;
         addr_wr_q <= 1'b0;
         ptr_next_q <= 1'b0;
         scl_oe_q <= 1'b0;
         sda_oe_q <= 1'b0;
         cmd_ready <= 1'b1;
         rsp_valid <= 1'b0;
         rsp_data <= '0;
         rsp_ack <= 1'b0;
      end else begin
         rsp_valid <= 1'b0;
         if (take && bad_ptr) begin
            // Test-mode pointers never reach the bus; refused with no ack
            rsp_valid <= 1'b1;
            rsp_ack <= 1'b0;
            rsp_data <= cmd_data;
         end else if (take) begin
            cmd_ready <= 1'b0;
            tx_q <= cmd_data;
            stop_q <= cmd_stop;
            read_q <= cmd_read && !cmd_start;
            nack_q <= cmd_nack;
            addr_wr_q <= cmd_start && cmd_data[0] == RTCI_DIR_WRITE;
            bit_q <= '0;
            ph_q <= RTCI_PH_SETUP;
            st_q <= (cmd_start || st_q == RTCI_H_IDLE) ? RTCI_H_START : RTCI_H_BITS;
         end else if (tick) begin
            ph_q <= ph_q + 1'b1;
            unique case (st_q)
               RTCI_H_IDLE, RTCI_H_HOLD: begin
                  ph_q <= RTCI_PH_SETUP;
               end
               RTCI_H_START: begin
                  unique case (ph_q)
                     RTCI_PH_SETUP: sda_oe_q <= 1'b0;
                     RTCI_PH_RISE: scl_oe_q <= 1'b0;
                     RTCI_PH_MID: sda_oe_q <= 1'b1;
                     RTCI_PH_FALL: begin
                        scl_oe_q <= 1'b1;
                        st_q <= RTCI_H_BITS;
                     end
                  endcase
               end
               RTCI_H_BITS: begin
                  unique case (ph_q)
                     RTCI_PH_SETUP: begin
                        // Data moves only while SCL is low
                        if (bit_q == RTCI_BYTE_BITS) begin
                           sda_oe_q <= read_q && !nack_q;
                        end else begin
                           sda_oe_q <= !read_q && !tx_q[7];
                           tx_q <= {tx_q[6:0], 1'b0};
                        end
                     end
                     RTCI_PH_RISE: scl_oe_q <= 1'b0;
                     RTCI_PH_MID: begin
                        if (bit_q == RTCI_BYTE_BITS) begin
                           rsp_ack <= !sda_s_q;
                        end else begin
                           rx_q <= {rx_q[6:0], sda_s_q};
                        end
                     end
                     RTCI_PH_FALL: begin
                        scl_oe_q <= 1'b1;
                        if (bit_q == RTCI_BYTE_BITS) begin
                           rsp_valid <= 1'b1;
                           rsp_data <= rx_q;
                           ptr_next_q <= addr_wr_q && rsp_ack;
                           st_q <= stop_q ? RTCI_H_STOP : RTCI_H_HOLD;
                           cmd_ready <= !stop_q;
                        end else begin
                           bit_q <= bit_q + 1'b1;
                        end
                     end
                  endcase
               end
               RTCI_H_STOP: begin
                  unique case (ph_q)
                     RTCI_PH_SETUP: sda_oe_q <= 1'b1;
                     RTCI_PH_RISE: scl_oe_q <= 1'b0;
                     RTCI_PH_MID: sda_oe_q <= 1'b0;
                     RTCI_PH_FALL: begin
                        st_q <= RTCI_H_IDLE;
                        ptr_next_q <= 1'b0;
                        cmd_ready <= 1'b1;
                     end
                  endcase
               end
               default: st_q <= RTCI_H_IDLE;
            endcase
         end
      end
   end
endmodule

// File: verif/rtci_bus_monitor.sv
// Concurrent checks on the two-wire bus between controller and clock target
`timescale 1ns/100ps
module rtci_bus_monitor
   import rtci_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic link_clk,
   input wire logic link_rst,
   input wire logic host_scl_o,
   input wire logic host_scl_oe,
   input wire logic host_sda_o,
   input wire logic host_sda_oe,
   input wire logic dev_sda_o,
   input wire logic dev_sda_oe,
   input wire logic scl,
   input wire logic sda
);
   logic scl_q, sda_q, busy_q, first_q, rd_q, nack_q, wait_q;
   logic [3:0] bc_q;
   logic [7:0] sh_q;
   logic rise, fall, start_w, stop_w, hit;
   assign rise = scl && !scl_q;
   assign fall = !scl && scl_q;
   assign start_w = scl && scl_q && sda_q && !sda;
   assign stop_w = scl && scl_q && !sda_q && sda;
   assign hit = (sh_q[7:1] == RTCI_TARGET_ADDR);
   always_ff @(posedge ref_clk) begin
      scl_q <= rst ? 1'b1 : scl;
      sda_q <= rst ? 1'b1 : sda;
   end
   // Bit position within the byte; 9 is the acknowledge clock
   always_ff @(posedge ref_clk) begin
      if (rst || start_w || stop_w) begin
         bc_q <= 4'h0;
      end else if (rise) begin
         bc_q <= (bc_q == 4'h9) ? 4'h1 : bc_q + 4'h1;
      end
   end
   always_ff @(posedge ref_clk) begin
      if (rise && bc_q != 4'h8) begin
         sh_q <= {sh_q[6:0], sda};
      end
   end
   always_ff @(posedge ref_clk) begin
      if (rise && bc_q == 4'h8) begin
         nack_q <= sda;
      end
      if (fall && bc_q == 4'h9 && first_q) begin
         rd_q <= sh_q[0];
      end
   end
   always_ff @(posedge ref_clk) begin
      if (rst || stop_w) begin
         busy_q <= 1'b0;
         first_q <= 1'b0;
      end else if (start_w) begin
         busy_q <= 1'b1;
         first_q <= 1'b1;
      end else if (fall && bc_q == 4'h9) begin
         first_q <= 1'b0;
      end
   end
   always_ff @(posedge ref_clk) begin
      if (rst || start_w || stop_w) begin
         wait_q <= 1'b0;
      end else if (fall && bc_q == 4'h9 && !first_q && rd_q && nack_q) begin
         wait_q <= 1'b1;
      end
   end
   a_ctrl_reset_idle: assert property (@(posedge ref_clk) rst |=> !host_scl_oe && !host_sda_oe)
      else $error("controller holds a line after reset");
   a_dev_reset_idle: assert property (@(posedge link_clk) link_rst |=> !dev_sda_oe)
      else $error("target holds data line after reset");
   a_idle_bus_high: assert property (@(posedge ref_clk) disable iff (rst)
      !busy_q && !start_w |-> scl && sda)
      else $error("line low outside a frame");
   a_open_drain_only: assert property (@(posedge ref_clk) disable iff (rst)
      !(host_scl_oe && host_scl_o) && !(host_sda_oe && host_sda_o) && !(dev_sda_oe && dev_sda_o))
      else $error("a line is driven high");
   a_dev_edge_low: assert property (@(posedge ref_clk) disable iff (rst || link_rst)
      $changed(dev_sda_oe) |-> !scl && !scl_q)
      else $error("target moved data line while clock high");
   a_addr_ack_match: assert property (@(posedge ref_clk) disable iff (rst)
      rise && bc_q == 4'h8 && first_q |-> sda == !hit)
      else $error("address acknowledge does not follow address match");
   a_ack_held_fall: assert property (@(posedge ref_clk) disable iff (rst)
      fall && bc_q == 4'h9 && first_q && hit |-> !sda_q)
      else $error("address acknowledge dropped before ninth fall");
   a_write_release: assert property (@(posedge ref_clk) disable iff (rst)
      fall && bc_q == 4'h9 && busy_q && !(first_q ? sh_q[0] : rd_q) |-> ##[1:100] !dev_sda_oe)
      else $error("target kept data line after ninth fall");
   a_nack_wait_stop: assert property (@(posedge ref_clk) disable iff (rst) wait_q |-> !dev_sda_oe)
      else $error("target drives data after withheld acknowledge");
   c_restart: cover property (@(posedge ref_clk) start_w && busy_q);
   c_full_nack: cover property (@(posedge ref_clk) fall && bc_q == 4'h9 && !first_q && !rd_q && nack_q);
   c_read_end: cover property (@(posedge ref_clk) wait_q && stop_w);
   c_wrong_addr: cover property (@(posedge ref_clk) rise && bc_q == 4'h8 && first_q && !hit);
endmodule

// File: verif/rtc_i2c_target_interface_tb_top.sv
// Bench joining controller and clock target over the two-wire bus
`timescale 1ns/100ps
module rtc_i2c_target_interface_tb_top
   import rtci_pkg::*;
   ();
   logic ref_clk, link_clk, rst, link_rst;
   logic cmd_valid, cmd_ready, cmd_start, cmd_stop, cmd_read, cmd_nack;
   logic rsp_valid, rsp_ack, wr_valid, wr_ready, seen_ack;
   logic [7:0] cmd_data, rsp_data, rd_addr, rd_data, wr_addr, wr_data, wsh, seen_byte;
   int bcnt, n_mismatch, compares;
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   initial begin
      link_clk = 1'b0;
      #7.3;
      forever #32 link_clk = ~link_clk;
   end
   // Register file stand-in: contents are a fixed function of the pointer
   assign rd_data = rd_addr ^ 8'h5A;
   rtci_bus_if rtci_bus_if_i ();
   rtci_controller #(.QUARTER_CYC(64)) rtci_controller_i (.ref_clk(ref_clk), .rst(rst),
      .bus(rtci_bus_if_i), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_start(cmd_start),
      .cmd_stop(cmd_stop), .cmd_read(cmd_read), .cmd_nack(cmd_nack), .cmd_data(cmd_data),
      .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_ack(rsp_ack));
   rtci_target rtci_target_i (.link_clk(link_clk), .rst(link_rst), .bus(rtci_bus_if_i),
      .rd_addr(rd_addr), .rd_data(rd_data), .wr_valid(wr_valid), .wr_ready(wr_ready),
      .wr_addr(wr_addr), .wr_data(wr_data));
   rtci_bus_monitor rtci_bus_monitor_i (.ref_clk(ref_clk), .rst(rst), .link_clk(link_clk),
      .link_rst(link_rst), .host_scl_o(rtci_bus_if_i.host_scl_o),
      .host_scl_oe(rtci_bus_if_i.host_scl_oe), .host_sda_o(rtci_bus_if_i.host_sda_o),
      .host_sda_oe(rtci_bus_if_i.host_sda_oe), .dev_sda_o(rtci_bus_if_i.dev_sda_o),
      .dev_sda_oe(rtci_bus_if_i.dev_sda_oe), .scl(rtci_bus_if_i.scl), .sda(rtci_bus_if_i.sda));
   // Own byte capture from the wire, independent of either end
   always @(posedge rtci_bus_if_i.scl) begin
      if (bcnt == 8) begin
         seen_byte = wsh;
         seen_ack = rtci_bus_if_i.sda;
      end
      wsh = {wsh[6:0], rtci_bus_if_i.sda};
      bcnt = (bcnt == 8) ? 0 : bcnt + 1;
   end
   always @(negedge rtci_bus_if_i.sda) begin
      if (rtci_bus_if_i.scl === 1'b1) begin
         bcnt = 0;
      end
   end
   task automatic check(input string what, input logic [16:0] seen, input logic [16:0] exp);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic complete_run();
      $display("compares %0d n_mismatch %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // One byte; on reads d is the byte expected back, on writes ea the ack expected
   task automatic send(input logic st, sp, rd, nk, input logic [7:0] d, input logic ea);
      int n;
      n = 0;
      // Let an edge pass so a back-to-back call never lowers and raises valid in one step
      @(negedge ref_clk);
      while (cmd_ready !== 1'b1 && n < 9000) begin
         @(negedge ref_clk);
         n++;
      end
      {cmd_start, cmd_stop, cmd_read, cmd_nack, cmd_data} = {st, sp, rd, nk, d};
      cmd_valid = 1'b1;
      @(negedge ref_clk);
      cmd_valid = 1'b0;
      n = 0;
      while (rsp_valid !== 1'b1 && n < 9000) begin
         @(negedge ref_clk);
         n++;
      end
      check("response", n < 9000, 1'b1);
      if (rd) begin
         check("read byte", rsp_data, d);
         check("wire read byte", seen_byte, d);
         check("wire master ack", seen_ack, nk);
      end else begin
         check("ack", rsp_ack, ea);
         if (d !== RTCI_TEST_PTR_A && d !== RTCI_TEST_PTR_B) begin
            check("wire byte", seen_byte, d);
            check("wire ack", seen_ack, !ea);
         end
      end
   endtask
   task automatic settle(input logic [7:0] ptr);
      repeat (200) @(negedge ref_clk);
      check("idle scl", rtci_bus_if_i.scl, 1'b1);
      check("idle sda", rtci_bus_if_i.sda, 1'b1);
      check("pointer", rd_addr, ptr);
   endtask
   task automatic t_fill();
      int i;
      wr_ready = 1'b0;
      send(1, 0, 0, 0, 8'hA2, 1);
      send(0, 0, 0, 0, 8'h10, 1);
      for (i = 0; i < 16; i++) begin
         send(0, 0, 0, 0, 8'hC0 + 8'(i), 1);
      end
      // Buffer full, so the seventeenth byte is refused and leaves the pointer alone
      send(0, 1, 0, 0, 8'hEE, 0);
      settle(8'h20);
      @(negedge link_clk);
      wr_ready = 1'b1;
      for (i = 0; i < 16; i++) begin
         check("fifo word", {wr_valid, wr_addr, wr_data}, {1'b1, 8'h10 + 8'(i), 8'hC0 + 8'(i)});
         @(negedge link_clk);
      end
      check("fifo empty", wr_valid, 1'b0);
      @(negedge ref_clk);
      $display("fill and drain test done");
   endtask
   task automatic t_reads();
      send(1, 0, 0, 0, 8'hA3, 1);
      send(0, 0, 1, 0, 8'h20 ^ 8'h5A, 0);
      send(0, 1, 1, 1, 8'h21 ^ 8'h5A, 0);
      settle(8'h22);
      send(1, 0, 0, 0, 8'hA2, 1);
      send(0, 0, 0, 0, 8'h30, 1);
      send(1, 0, 0, 0, 8'hA3, 1);
      send(0, 1, 1, 1, 8'h30 ^ 8'h5A, 0);
      settle(8'h31);
      $display("read test done");
   endtask
   task automatic t_wrong_addr();
      send(1, 1, 0, 0, 8'h22, 0);
      send(1, 1, 0, 0, 8'hA0, 0);
      settle(8'h31);
      $display("foreign address test done");
   endtask
   task automatic t_refuse();
      int k;
      for (k = 0; k < 2; k++) begin
         send(1, 0, 0, 0, 8'hA2, 1);
         send(0, 0, 0, 0, (k == 0) ? RTCI_TEST_PTR_A : RTCI_TEST_PTR_B, 0);
         check("ready after refusal", cmd_ready, 1'b1);
         send(0, 1, 0, 0, 8'h05 + 8'(k), 1);
         settle(8'h05 + 8'(k));
      end
      $display("reserved pointer test done");
   endtask
   initial begin
      n_mismatch = 0;
      compares = 0;
      bcnt = 0;
      wsh = 8'h00;
      rst = 1'b1;
      link_rst = 1'b1;
      {cmd_valid, cmd_start, cmd_stop, cmd_read, cmd_nack, cmd_data} = 13'h0000;
      wr_ready = 1'b0;
      repeat (6) @(negedge ref_clk);
      rst = 1'b0;
      repeat (4) @(negedge link_clk);
      link_rst = 1'b0;
      repeat (4) @(negedge link_clk);
      @(negedge ref_clk);
      check("reset state", {cmd_ready, rsp_valid, wr_valid, rd_addr}, {3'b100, RTCI_PTR_RESET});
      t_fill();
      t_reads();
      t_wrong_addr();
      t_refuse();
      complete_run();
   end
   // Expected run is near 400 us; stop a hang well before the cycle budget
   initial begin
      #470000;
      n_mismatch++;
      $display("ERROR watchdog expired");
      complete_run();
   end
endmodule
